// ### core/fsiu_pkg.sv
// package of constants and carrier types for the four source interrupt unit
`default_nettype none
package fsiu_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_EDGE   = 8'hBF;
  localparam logic [7:0] ADDR_REQ    = 8'hC8;
  localparam logic [7:0] ADDR_EN     = 8'hC9;
  localparam logic [7:0] ADDR_STK    = 8'hDF;
  localparam logic [7:0] SRC_MASK    = 8'h53;
  localparam int         BIT_PIN0    = 0;
  localparam int         BIT_PIN1    = 1;
  localparam int         BIT_TMRA    = 4;
  localparam int         BIT_TMRB    = 6;
  localparam int         BIT_GIE     = 7;
  localparam logic [2:0] STK_RESET   = 3'h7;
  localparam logic [1:0] EDGE_RESET  = 2'h2;
  localparam logic [1:0] EDGE_RISE   = 2'h1;
  localparam logic [1:0] EDGE_FALL   = 2'h2;
  localparam logic [1:0] EDGE_BOTH   = 2'h3;
  localparam logic [11:0] VECTOR     = 12'h008;
  // processor flags bits kept out of the save buffer
  localparam logic [7:0] KEEP_MASK   = 8'hC0;

  typedef struct packed {
    logic [1:0] sync0;
    logic [1:0] sync1;
    logic       last0;
    logic       last1;
    logic [7:0] req;
    logic [7:0] en;
    logic [1:0] edge_sel;
    logic       global_interrupt_enable;
    logic [2:0] level;
    logic [7:0] save_acc;
    logic [7:0] save_flags;
    logic [7:0] rdata;
    logic       take;
    logic [11:0] pc;
    logic       pc_load;
    logic [7:0] acc_out;
    logic [7:0] flags_out;
    logic       restore;
  } fsiu_state_s;
endpackage
`default_nettype wire

// ### core/fsiu_top.sv
// interrupt unit: flags, enables, global enable, vector entry, save buffer
`default_nettype none
module fsiu_top (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // pins and timers
  input  wire logic        ext_pin0,
  input  wire logic        ext_pin1,
  input  wire logic        timer_a_ovf,
  input  wire logic        timer_b_ovf,
  // core sequencer
  input  wire logic        core_ready,
  input  wire logic        return_from_service,
  input  wire logic        push_req,
  input  wire logic        pop_req,
  input  wire logic [7:0]  accumulator,
  input  wire logic [7:0]  processor_flags,
  output logic             take_interrupt,
  output logic      [11:0] pc_load_value,
  output logic             pc_load,
  output logic      [2:0]  stack_level_bits,
  output logic      [7:0]  acc_restore,
  output logic      [7:0]  flags_restore,
  output logic             restore_valid,
  output logic             irq
);
  fsiu_pkg::fsiu_state_s s, n;
  logic [7:0] ev;
  logic       p0;
  logic       p1;
  logic       pending;

  // ****************************************
  // helpers
  // ****************************************
  // strobe aimed at one register
  function automatic logic write_hit(input logic       strobe,
                                     input logic [7:0] where,
                                     input logic [7:0] target);
    return strobe && (where == target);
  endfunction

  // trigger of the pin0 detector for the chosen edge
  function automatic logic edge_event(input logic [1:0] sel,
                                      input logic       now,
                                      input logic       prev);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      fsiu_pkg::EDGE_RISE: hit = now & ~prev;
      fsiu_pkg::EDGE_FALL: hit = ~now & prev;
      fsiu_pkg::EDGE_BOTH: hit = now ^ prev;
      default:             hit = 1'b0;
    endcase
    return hit;
  endfunction

  // falling edge of a synchronised pin
  function automatic logic fall_event(input logic now,
                                      input logic prev);
    return ~now & prev;
  endfunction

  // read image of the edge select register
  function automatic logic [7:0] edge_image(input logic [1:0] sel);
    return {3'h0, sel, 3'h0};
  endfunction

  // read image of the stack and global enable register
  function automatic logic [7:0] stack_image(input logic       global_interrupt_enable,
                                             input logic [2:0] level);
    return {global_interrupt_enable, 4'h0, level};
  endfunction

  // processor flags with the kept bits taken from the live value
  function automatic logic [7:0] merge_flags(input logic [7:0] saved,
                                             input logic [7:0] live);
    return (saved & ~fsiu_pkg::KEEP_MASK) | (live & fsiu_pkg::KEEP_MASK);
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = s;
    p0 = s.sync0[1];
    p1 = s.sync1[1];
    n.sync0 = {s.sync0[0], ext_pin0};
    n.sync1 = {s.sync1[0], ext_pin1};
    n.last0 = p0;
    n.last1 = p1;
    ev = 8'h00;
    ev[fsiu_pkg::BIT_PIN0] = edge_event(s.edge_sel, p0,
                                        s.last0);
    ev[fsiu_pkg::BIT_PIN1] = fall_event(p1, s.last1);
    ev[fsiu_pkg::BIT_TMRA] = timer_a_ovf;
    ev[fsiu_pkg::BIT_TMRB] = timer_b_ovf;
    // register writes; a set event wins over a cleared bit
    if (write_hit(wr, addr, fsiu_pkg::ADDR_REQ))
      n.req = wdata & fsiu_pkg::SRC_MASK;
    if (write_hit(wr, addr, fsiu_pkg::ADDR_EN))
      n.en = wdata & fsiu_pkg::SRC_MASK;
    if (write_hit(wr, addr, fsiu_pkg::ADDR_EDGE))
      n.edge_sel = wdata[4:3];
    if (write_hit(wr, addr, fsiu_pkg::ADDR_STK)) begin
      n.global_interrupt_enable   = wdata[fsiu_pkg::BIT_GIE];
      n.level = wdata[2:0];
    end
    n.req = n.req | ev;
    // single vector entry, no priority among sources
    pending = |(s.req & s.en);
    n.take = 1'b0;
    n.pc_load = 1'b0;
    if (s.global_interrupt_enable && pending && core_ready && !s.take) begin
      n.take    = 1'b1;
      n.pc_load = 1'b1;
      n.pc      = fsiu_pkg::VECTOR;
      n.level   = s.level - 3'h1;
      n.global_interrupt_enable     = 1'b0;
    end else if (return_from_service) begin
      n.level = s.level + 3'h1;
      n.global_interrupt_enable   = 1'b1;
    end
    // one level save buffer
    n.restore = 1'b0;
    if (push_req) begin
      n.save_acc   = accumulator;
      n.save_flags = processor_flags & ~fsiu_pkg::KEEP_MASK;
    end
    if (pop_req) begin
      n.restore   = 1'b1;
      n.acc_out   = s.save_acc;
      n.flags_out = merge_flags(s.save_flags, processor_flags);
    end
    n.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        fsiu_pkg::ADDR_REQ:  n.rdata = s.req;
        fsiu_pkg::ADDR_EN:   n.rdata = s.en;
        fsiu_pkg::ADDR_EDGE: n.rdata = edge_image(s.edge_sel);
        fsiu_pkg::ADDR_STK:  n.rdata = stack_image(s.global_interrupt_enable, s.level);
        default:             n.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s          <= '0;
      s.level    <= fsiu_pkg::STK_RESET;
      s.edge_sel <= fsiu_pkg::EDGE_RESET;
      s.sync0    <= 2'h0;
      s.sync1    <= 2'h3;
      s.last1    <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign rdata            = s.rdata;
  assign take_interrupt   = s.take;
  assign pc_load_value    = s.pc;
  assign pc_load          = s.pc_load;
  assign stack_level_bits = s.level;
  assign acc_restore      = s.acc_out;
  assign flags_restore    = s.flags_out;
  assign restore_valid    = s.restore;
  assign irq              = s.take;

  // ****************************************
  // checks
  // ****************************************
  // entry and return
  a_entry_clears_gie: assert property (
    @(posedge clock) disable iff (rst)
    s.take |-> !s.global_interrupt_enable)
    else $error("gie not cleared on entry");

  a_entry_vector: assert property (
    @(posedge clock) disable iff (rst)
    s.take |-> s.pc == fsiu_pkg::VECTOR
               && s.level == $past(s.level) - 3'h1)
    else $error("bad vector entry");

  a_no_take_gie: assert property (
    @(posedge clock) disable iff (rst)
    s.take |-> $past(s.global_interrupt_enable))
    else $error("taken without gie");

  a_take_enabled: assert property (
    @(posedge clock) disable iff (rst)
    s.take |-> |($past(s.req) & $past(s.en)))
    else $error("disabled taken");

  a_return_sets_gie: assert property (
    @(posedge clock) disable iff (rst)
    (return_from_service && !n.take
     && !write_hit(wr, addr, fsiu_pkg::ADDR_STK)) |=> s.global_interrupt_enable)
    else $error("gie not set on return");

  a_return_level: assert property (
    @(posedge clock) disable iff (rst)
    (return_from_service && !n.take
     && !write_hit(wr, addr, fsiu_pkg::ADDR_STK))
    |=> s.level == $past(s.level) + 3'h1)
    else $error("level not raised on return");

  a_take_single: assert property (
    @(posedge clock) disable iff (rst)
    s.take |=> !s.take)
    else $error("entry longer than one cycle");

  a_take_ready: assert property (
    @(posedge clock) disable iff (rst)
    s.take |-> $past(core_ready))
    else $error("entry while core busy");

  a_load_pair: assert property (
    @(posedge clock) disable iff (rst)
    s.pc_load == s.take)
    else $error("pc load apart from entry");

  a_gie_blocks: assert property (
    @(posedge clock) disable iff (rst)
    !s.global_interrupt_enable |=> !s.take)
    else $error("entry with gie clear");

  a_none_enabled: assert property (
    @(posedge clock) disable iff (rst)
    ((s.req & s.en) == 8'h00) |=> !s.take)
    else $error("entry with nothing enabled");

  a_level_steady: assert property (
    @(posedge clock) disable iff (rst)
    (!n.take && !return_from_service
     && !write_hit(wr, addr, fsiu_pkg::ADDR_STK)) |=> $stable(s.level))
    else $error("level moved on its own");

  // request flags
  a_timer_a_flag: assert property (
    @(posedge clock) disable iff (rst)
    timer_a_ovf |=> s.req[fsiu_pkg::BIT_TMRA])
    else $error("timer a flag missing");

  a_timer_b_flag: assert property (
    @(posedge clock) disable iff (rst)
    timer_b_ovf |=> s.req[fsiu_pkg::BIT_TMRB])
    else $error("timer b flag missing");

  a_pin0_flag: assert property (
    @(posedge clock) disable iff (rst)
    ev[fsiu_pkg::BIT_PIN0] |=> s.req[fsiu_pkg::BIT_PIN0])
    else $error("pin0 flag missing");

  a_pin1_flag: assert property (
    @(posedge clock) disable iff (rst)
    ev[fsiu_pkg::BIT_PIN1] |=> s.req[fsiu_pkg::BIT_PIN1])
    else $error("pin1 flag missing");

  a_flag_sticky: assert property (
    @(posedge clock) disable iff (rst)
    (s.req[fsiu_pkg::BIT_PIN0]
     && !write_hit(wr, addr, fsiu_pkg::ADDR_REQ)) |=> s.req[0])
    else $error("flag dropped");

  a_flag_write: assert property (
    @(posedge clock) disable iff (rst)
    (write_hit(wr, addr, fsiu_pkg::ADDR_REQ) && ev == 8'h00)
    |=> s.req == ($past(wdata) & fsiu_pkg::SRC_MASK))
    else $error("flag write lost");

  a_req_layout: assert property (
    @(posedge clock) disable iff (rst)
    (s.req & ~fsiu_pkg::SRC_MASK) == 8'h00)
    else $error("flag outside source bits");

  a_flags_kept: assert property (
    @(posedge clock) disable iff (rst)
    !write_hit(wr, addr, fsiu_pkg::ADDR_REQ)
    |=> (s.req & $past(s.req)) == $past(s.req))
    else $error("flag cleared without a write");

  // edge detectors
  a_pin1_fall_only: assert property (
    @(posedge clock) disable iff (rst)
    (s.sync1[1] && !s.last1) |-> !ev[fsiu_pkg::BIT_PIN1])
    else $error("pin1 rising edge taken");

  a_pin1_fall_seen: assert property (
    @(posedge clock) disable iff (rst)
    (!s.sync1[1] && s.last1) |-> ev[fsiu_pkg::BIT_PIN1])
    else $error("pin1 falling edge missed");

  a_rise_only: assert property (
    @(posedge clock) disable iff (rst)
    (s.edge_sel == fsiu_pkg::EDGE_RISE && s.sync0[1] != s.last0)
    |-> ev[fsiu_pkg::BIT_PIN0] == s.sync0[1])
    else $error("pin0 rise select wrong");

  a_fall_only: assert property (
    @(posedge clock) disable iff (rst)
    (s.edge_sel == fsiu_pkg::EDGE_FALL && s.sync0[1] != s.last0)
    |-> ev[fsiu_pkg::BIT_PIN0] == s.last0)
    else $error("pin0 fall select wrong");

  a_both_edges: assert property (
    @(posedge clock) disable iff (rst)
    (s.edge_sel == fsiu_pkg::EDGE_BOTH && s.sync0[1] != s.last0)
    |-> ev[fsiu_pkg::BIT_PIN0])
    else $error("pin0 both select wrong");

  a_edge_reserved: assert property (
    @(posedge clock) disable iff (rst)
    (s.edge_sel == 2'h0) |-> !ev[fsiu_pkg::BIT_PIN0])
    else $error("pin0 trigger on reserved select");

  // register port
  a_enable_write: assert property (
    @(posedge clock) disable iff (rst)
    write_hit(wr, addr, fsiu_pkg::ADDR_EN)
    |=> s.en == ($past(wdata) & fsiu_pkg::SRC_MASK))
    else $error("enable write lost");

  a_edge_write: assert property (
    @(posedge clock) disable iff (rst)
    write_hit(wr, addr, fsiu_pkg::ADDR_EDGE)
    |=> s.edge_sel == $past(wdata[4:3]))
    else $error("edge select write lost");

  a_gie_write: assert property (
    @(posedge clock) disable iff (rst)
    (write_hit(wr, addr, fsiu_pkg::ADDR_STK) && !n.take
     && !return_from_service)
    |=> s.global_interrupt_enable == $past(wdata[fsiu_pkg::BIT_GIE]))
    else $error("global enable write lost");

  a_read_flags: assert property (
    @(posedge clock) disable iff (rst)
    (rd && addr == fsiu_pkg::ADDR_REQ) |=> rdata == $past(s.req))
    else $error("flag read wrong");

  a_read_enable: assert property (
    @(posedge clock) disable iff (rst)
    (rd && addr == fsiu_pkg::ADDR_EN) |=> rdata == $past(s.en))
    else $error("enable read wrong");

  // save buffer
  a_push_save: assert property (
    @(posedge clock) disable iff (rst)
    push_req |=> s.save_acc == $past(accumulator))
    else $error("accumulator not saved");

  a_pop_restore: assert property (
    @(posedge clock) disable iff (rst)
    pop_req |=> restore_valid && acc_restore == $past(s.save_acc))
    else $error("bad restore");

  a_pop_kept: assert property (
    @(posedge clock) disable iff (rst)
    pop_req |=> (flags_restore & fsiu_pkg::KEEP_MASK)
                == ($past(processor_flags) & fsiu_pkg::KEEP_MASK))
    else $error("status bits restored from buffer");

  c_entry: cover property (@(posedge clock) s.take);
  c_return: cover property (@(posedge clock) return_from_service);
  c_pin1_edge: cover property (@(posedge clock) ev[1]);
  c_restore: cover property (@(posedge clock) restore_valid);
  c_multi: cover property (@(posedge clock) s.take && s.req[4] && s.req[6]);
endmodule
`default_nettype wire

// ### testbench/fsiu_core_model.sv
// core sequencer stand-in facing the interrupt unit
`default_nettype none
module fsiu_core_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // unit side
  input  wire logic       take_interrupt,
  input  wire logic       svc_done,
  output logic            core_ready,
  output logic            push_req,
  output logic            pop_req,
  output logic            return_from_service,
  output logic      [7:0] accumulator,
  output logic      [7:0] processor_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // push on entry, pop then return when service ends
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {core_ready, push_req, pop_req, return_from_service} <= 4'h0;
      {accumulator, processor_flags} <= 16'hA5FF;
    end else begin
      core_ready <= 1'b1;
      push_req <= take_interrupt;
      pop_req <= svc_done;
      return_from_service <= pop_req;
      if (push_req) begin
        {accumulator, processor_flags} <= 16'h3C00;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/fsiu_top_test.sv
// self-checking bench for the four source interrupt unit
`default_nettype none
module fsiu_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        ext_pin0 = 1'b0, ext_pin1 = 1'b1, svc_done = 1'b0;
  logic        timer_a_ovf = 1'b0, timer_b_ovf = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, accumulator, d;
  logic [7:0]  processor_flags, acc_restore, flags_restore;
  logic [11:0] pc_load_value;
  logic [2:0]  stack_level_bits;
  logic        core_ready, return_from_service, push_req, pop_req;
  logic        take_interrupt, pc_load, restore_valid, irq;
  int          num_errors = 0, total_checks = 0, cycles = 0, takes = 0;
  fsiu_top dut (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata, .ext_pin0,
    .ext_pin1, .timer_a_ovf, .timer_b_ovf, .core_ready,
    .return_from_service, .push_req, .pop_req, .accumulator,
    .processor_flags, .take_interrupt, .pc_load_value, .pc_load,
    .stack_level_bits, .acc_restore, .flags_restore, .restore_valid, .irq);
  fsiu_core_model core (.clock, .rst, .take_interrupt, .svc_done,
    .core_ready, .push_req, .pop_req, .return_from_service, .accumulator,
    .processor_flags);
  always #4 clock = ~clock;
  task automatic chk(input string n, input logic [11:0] e, g);
    total_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
      num_errors++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wreg(input logic [7:0] a, v);
    @(posedge clock);
    {addr, wdata, wr} <= {a, v, 1'b1};
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clock);
    {addr, rd} <= {a, 1'b1};
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic ovf(input logic [1:0] s);
    @(posedge clock);
    {timer_b_ovf, timer_a_ovf} <= s;
    @(posedge clock);
    {timer_b_ovf, timer_a_ovf} <= 2'h0;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      final_report();
    end
  end
  always @(negedge clock) begin
    if (take_interrupt === 1'b1) begin
      takes++;
      chk("vector", 12'h008, pc_load_value);
      chk("pc_load", 1'b1, pc_load);
      chk("irq", 1'b1, irq);
    end
  end
  initial begin
    tick(12);
    rst <= 1'b0;
    tick(2);
    chk("level", 3'h7, stack_level_bits);
    rreg(8'hC8); chk("req", 8'h00, d);
    rreg(8'hBF); chk("edge", 8'h10, d);
    rreg(8'h00); chk("unmapped", 8'h00, d);
    wreg(8'hC9, 8'hFF); rreg(8'hC9); chk("en", 8'h53, d);
    wreg(8'hC9, 8'h00);
    for (int m = 1; m < 4; m++) begin
      wreg(8'hBF, 8'(m << 3));
      wreg(8'hC8, 8'h00);
      @(posedge clock) ext_pin0 <= 1'b1;
      tick(6); rreg(8'hC8); chk("rise", 8'(m & 1), d);
      wreg(8'hC8, 8'h00);
      @(posedge clock) ext_pin0 <= 1'b0;
      tick(6); rreg(8'hC8); chk("fall", 8'(m & 2) >> 1, d);
    end
    wreg(8'hC8, 8'h00);
    @(posedge clock) ext_pin1 <= 1'b0;
    tick(6); rreg(8'hC8); chk("pin1 fall", 8'h02, d);
    wreg(8'hC8, 8'h00);
    @(posedge clock) ext_pin1 <= 1'b1;
    tick(6); rreg(8'hC8); chk("pin1 rise", 8'h00, d);
    wreg(8'hC9, 8'h40); ovf(2'h2); tick(4);
    rreg(8'hC8); chk("tmrb", 8'h40, d);
    wreg(8'hC9, 8'h00); wreg(8'hDF, 8'h87); ovf(2'h1); tick(4);
    rreg(8'hC8); chk("tmra", 8'h50, d);
    chk("no take", 12'h0, 12'(takes));
    wreg(8'hC9, 8'h50); tick(10);
    chk("one take", 12'h1, 12'(takes));
    chk("level in", 3'h6, stack_level_bits);
    rreg(8'hDF); chk("gie off", 1'b0, d[7]);
    rreg(8'hC8); chk("kept", 8'h50, d);
    wreg(8'hC8, 8'h00);
    @(posedge clock) svc_done <= 1'b1;
    @(posedge clock) svc_done <= 1'b0;
    for (int i = 0; i < 20 && restore_valid !== 1'b1; i++) @(negedge clock);
    chk("restore", 1'b1, restore_valid);
    chk("acc", 8'hA5, acc_restore);
    chk("flags", 8'h3F, flags_restore & 8'h3F);
    tick(4);
    chk("level out", 3'h7, stack_level_bits);
    rreg(8'hDF); chk("gie on", 1'b1, d[7]);
    chk("takes", 12'h1, 12'(takes));
    final_report();
  end
endmodule
`default_nettype wire
